// ### hw/cpr_pkg.sv
// Purpose: Shared constants and types for the clock, power and reset control.
// Assumes: One clock domain (clk_sys, 250 MHz), plain register port.
// Notes:   Offsets are word-aligned byte addresses.
package cpr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] OFF_OSC_CTRL  = 8'h00; // Oscillator halt bits
  localparam logic [7:0] OFF_FREQ_SEL  = 8'h04; // Fast osc frequency code
  localparam logic [7:0] OFF_CLK_SEL   = 8'h08; // Processor clock source
  localparam logic [7:0] OFF_PMU_KEY   = 8'h0C; // Partial power-down arm key
  localparam logic [7:0] OFF_RST_CAUSE = 8'h10; // Sticky reset cause
  localparam logic [7:0] OFF_STATUS    = 8'h14; // Power state and clocks
  localparam logic [7:0] OFF_SW_RESET  = 8'h18; // Software reset request

  // ==========================================================================
  // Field positions and values
  // ==========================================================================
  localparam int BIT_MAIN_HALT = 0;             // Main osc halt bit
  localparam int BIT_FAST_HALT = 1;             // Fast internal osc halt bit
  localparam int BIT_SUB_HALT  = 2;             // Sub osc halt bit
  localparam logic [31:0] PMU_KEY_VALUE = 32'h0000_00A5; // Arm key value
  localparam logic [31:0] SW_RESET_KEY  = 32'h0000_005A; // Soft reset key
  localparam logic [2:0]  FREQ_MAX_CODE = 3'h5;  // Code for 64 MHz ceiling
  localparam logic [2:0]  OSC_CTRL_RST  = 3'h4;  // Sub osc halted at reset

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ          = 250;        // System clock rate
  localparam int XTAL_STAB_US     = 100;        // Crystal settling, least
  localparam int XTAL_STAB_CYC    = XTAL_STAB_US * CLK_MHZ; // Rounded exact
  localparam int RST_STRETCH_CYC  = 8;          // Reset tail after the last source cycle

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_FAST = 3'h0,                            // Fast internal RC osc
    SRC_MAIN = 3'h1,                            // Main crystal / ext clock
    SRC_SUB  = 3'h2,                            // Sub crystal / ext clock
    SRC_SLOW = 3'h3                             // Slow internal RC osc
  } clk_src_t;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,                        // Processor clocked
    ST_SLEEP = 5'b00010,                        // Processor clock gated
    ST_DEEP  = 5'b00100,                        // Fast oscillators stopped
    ST_PPD   = 5'b01000,                        // Peripherals unpowered
    ST_STAB  = 5'b10000                         // Crystal settling wait
  } pwr_state_t;

  typedef struct packed {
    logic ext_pin;                              // External pin interrupt
    logic key_in;                               // Key-input interrupt
    logic rtc;                                  // Real-time clock interrupt
    logic itv;                                  // Interval timer interrupt
    logic wdt;                                  // Watchdog interrupt
    logic other;                                // Any other enabled request
  } wake_t;

  typedef struct packed {
    logic sw;                                   // Software request
    logic illegal;                              // Illegal memory access
    logic supply_level_detector;                                  // Supply-level detector
    logic por;                                  // Power-on detector
    logic wdt;                                  // Watchdog runaway
    logic pin;                                  // External reset pin
  } rst_src_t;

endpackage : cpr_pkg

// ### hw/clock_power_reset_control.sv
// Purpose: Oscillator gating, low-power sequencing and reset merging.
// Assumes: Events from same-clock logic are one-cycle pulses or levels.
// Notes:   Analogue detectors supply digital compare levels only.
//
// What this block does
// RQ1: Deep sleep or halt bit stops main crystal
// RQ2: Reset leaves processor on fast internal osc; only reset_n reloads src_q, the six internal sources leave it as set
// RQ3: Deep sleep or halt bit stops fast osc
// RQ4: Fast osc freq from option, software changeable
// RQ5: External main clock ignored when main stopped
// RQ6: Sub halt bit stops sub crystal, ext input
// RQ7: Slow osc selectable; clocks watchdog, RTC, timer
// RQ8: Sleep gates only processor clock
// RQ9: Deep sleep stops both fast oscillators
// RQ10: Interrupt releases deep sleep; crystal waits settling
// RQ11: Arm key then deep sleep cuts peripheral power
// RQ12: Power-down released by five listed sources only
// RQ13: Sleep and deep sleep keep all state
// RQ14: Software reinitialises peripherals after power-down
// RQ15: Six sources merge into internal reset
// RQ16: Every reset identical; fetch from lowest addresses
// RQ17: Power-on detector holds reset while supply low
// RQ18: Level detector gives reset or interrupt by option
// RQ19: Level detector keeps working in deep sleep
// RQ20: Sleep wake reopens clock at first interrupt
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

module clock_power_reset_control
  import cpr_pkg::*;
#(
  parameter int STAB_CYC = XTAL_STAB_CYC      // Crystal wait, shortenable
) (
  input  wire logic        clk_sys,           // System clock
  input  wire logic        reset_n,           // Async reset, active low
  input  wire logic        external_reset_pin_n, // Reset pin, active low
  input  wire logic        por_low,           // Supply below power-on level
  input  wire logic        supply_level_low,  // Supply below detector level
  input  wire logic        lvd_mode_irq,      // Option: detector interrupts
  input  wire logic [2:0]  opt_freq_code,     // Option: fast osc frequency
  input  wire logic        wdt_runaway,       // Watchdog runaway pulse
  input  wire logic        illegal_access,    // Illegal memory access pulse
  input  wire logic        sleep_exec,        // Sleep instruction pulse
  input  wire logic        deep_sleep_exec,   // Deep sleep instruction pulse
  input  wire wake_t       wake_req,          // Enabled interrupt requests
  input  wire logic [7:0]  reg_addr,          // Register address
  input  wire logic [31:0] reg_wdata,         // Register write data
  input  wire logic        reg_wr,            // Write strobe
  input  wire logic        reg_rd,            // Read strobe
  output logic [31:0]      reg_rdata,         // Read data, one cycle later
  output logic             main_osc_en,       // Main crystal enable
  output logic             main_ext_clk_en,   // External main clock gate
  output logic             fast_osc_en,       // Fast internal osc enable
  output logic [2:0]       fast_osc_freq,     // Fast osc frequency code
  output logic             sub_osc_en,        // Sub crystal / ext input
  output logic [2:0]       cpu_clk_sel,       // Processor clock source
  output logic             cpu_clk_gate,      // Processor clock enable
  output logic             slow_osc_to_periph,// Slow osc to wdt/rtc/timer
  output logic             periph_power_en,   // Peripheral supply switch
  output logic             lvd_irq,           // Detector interrupt request
  output logic             internal_reset_n,  // Merged reset, active low
  output logic [31:0]      fetch_addr         // Start of execution
);

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  logic [2:0] pin_sync_q;                     // Three-stage pin chain
  logic       pin_low_q;                      // Settled pin level
  // Reset pin comes from outside; only stages 2 and 3 are compared
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync_q <= 3'h7;
      pin_low_q  <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], external_reset_pin_n};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_low_q <= ~pin_sync_q[2];
      end
    end
  end

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [2:0]  halt_q;                        // Software halt bits
  logic [2:0]  freq_q;                        // Fast osc frequency code
  logic        freq_init_q;                   // Option byte loaded
  clk_src_t    src_q;                         // Processor clock source
  logic        arm_q;                         // Power-down armed
  logic        sw_rst_q;                      // Software reset pulse
  rst_src_t    cause_q;                       // Sticky reset cause
  pwr_state_t  state_q;                       // Power state
  logic        stab_done;                     // Crystal wait expired
  logic        wr_hit_cause;                  // Cause register write

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_hit_cause = reg_wr && hit(reg_addr, OFF_RST_CAUSE);

  // Halt bits; RQ1, RQ3, RQ6 software stop control
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      halt_q <= OSC_CTRL_RST;
    end else if (reg_wr && hit(reg_addr, OFF_OSC_CTRL)) begin
      halt_q <= reg_wdata[2:0];             // RQ1
    end
  end

  // Frequency: option byte after reset, then software, capped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      freq_q      <= 3'h0;
      freq_init_q <= 1'b0;
    end else if (!freq_init_q) begin
      // Strap caught after release, never under reset
      freq_q      <= opt_freq_code;         // RQ4
      freq_init_q <= 1'b1;
    end else if (reg_wr && hit(reg_addr, OFF_FREQ_SEL)) begin
      // Codes above the ceiling clamp to 64 MHz
      freq_q <= (reg_wdata[2:0] > FREQ_MAX_CODE) ? FREQ_MAX_CODE
                                                 : reg_wdata[2:0]; // RQ4
    end
  end

  // Clock source select; defaults to fast osc
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_q <= SRC_FAST;                      // RQ2
    end else if (reg_wr && hit(reg_addr, OFF_CLK_SEL)) begin
      case (reg_wdata[1:0])
        2'h1:    src_q <= SRC_MAIN;
        2'h2:    src_q <= SRC_SUB;
        2'h3:    src_q <= SRC_SLOW;           // RQ7
        default: src_q <= SRC_FAST;
      endcase
    end
  end

  // Arm key; consumed by the deep sleep entry it enables
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arm_q <= 1'b0;
    end else if (reg_wr && hit(reg_addr, OFF_PMU_KEY)) begin
      arm_q <= (reg_wdata == PMU_KEY_VALUE); // RQ11
    end else if (deep_sleep_exec && state_q == ST_RUN) begin
      arm_q <= 1'b0;
    end
  end

  // Software reset pulse from keyed write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= reg_wr && hit(reg_addr, OFF_SW_RESET)
                  && (reg_wdata == SW_RESET_KEY);
    end
  end

  // ==========================================================================
  // Reset merge
  // ==========================================================================
  rst_src_t   src_now;                        // Live reset sources
  logic       any_rst;                        // Any source active
  logic [3:0] rst_cnt_q;                      // Stretch counter

  always_comb begin
    src_now.pin     = pin_low_q;
    src_now.wdt     = wdt_runaway;
    src_now.por     = por_low;                // RQ17
    src_now.supply_level_detector     = supply_level_low && !lvd_mode_irq; // RQ18 RQ19
    src_now.illegal = illegal_access;
    src_now.sw      = sw_rst_q;
  end
  assign any_rst = |src_now;                  // RQ15

  // Cause bits: set wins over a clearing write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= '0;
    end else begin
      cause_q <= (wr_hit_cause ? (cause_q & ~rst_src_t'(reg_wdata[5:0]))
                               : cause_q) | src_now;
    end
  end

  // Hold reset while any source is active, then stretch by the same fixed count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_q        <= 4'(RST_STRETCH_CYC);
      internal_reset_n <= 1'b0;
    end else if (any_rst) begin
      rst_cnt_q        <= 4'(RST_STRETCH_CYC); // RQ16
      internal_reset_n <= 1'b0;
    end else if (rst_cnt_q != 4'h0) begin
      rst_cnt_q        <= rst_cnt_q - 4'h1;
      internal_reset_n <= 1'b0;
    end else begin
      internal_reset_n <= 1'b1;
    end
  end

  // Fetch starts from the lowest two addresses after any reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetch_addr <= 32'h0000_0000;            // RQ16
    end else begin
      fetch_addr <= 32'h0000_0000;
    end
  end

  // Detector interrupt mode; stays live in every power state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lvd_irq <= 1'b0;
    end else begin
      lvd_irq <= supply_level_low && lvd_mode_irq; // RQ18 RQ19
    end
  end

  // ==========================================================================
  // Power state sequencer
  // ==========================================================================
  logic [31:0] stab_q;                        // Crystal wait counter
  logic        ppd_wake;                      // Allowed power-down wakers
  logic        any_wake;                      // Any enabled request

  assign ppd_wake = wake_req.ext_pin | wake_req.key_in | wake_req.rtc
                  | wake_req.itv | wake_req.wdt; // RQ12
  assign any_wake = ppd_wake | wake_req.other;
  assign stab_done = (stab_q == 32'h0);

  // State changes; registers are not touched, so state is kept (RQ13)
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RUN;
    end else if (any_rst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (deep_sleep_exec) begin
            state_q <= arm_q ? ST_PPD : ST_DEEP; // RQ9 RQ11
          end else if (sleep_exec) begin
            state_q <= ST_SLEEP;                // RQ8
          end
        end
        ST_SLEEP: begin
          if (any_wake) begin
            state_q <= ST_RUN;                  // RQ20
          end
        end
        ST_DEEP: begin
          if (any_wake) begin
            state_q <= (src_q == SRC_MAIN) ? ST_STAB : ST_RUN; // RQ10
          end
        end
        ST_PPD: begin
          if (ppd_wake) begin
            state_q <= (src_q == SRC_MAIN) ? ST_STAB : ST_RUN; // RQ12
          end
        end
        ST_STAB: begin
          if (stab_done) begin
            state_q <= ST_RUN;                  // RQ10
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // Crystal settling counter, reloaded in every cycle outside the wait
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stab_q <= 32'h0;
    end else if (state_q != ST_STAB) begin
      stab_q <= 32'(STAB_CYC - 1);
    end else if (!stab_done) begin
      stab_q <= stab_q - 32'h1;               // RQ10
    end
  end

  // ==========================================================================
  // Clock and power outputs
  // ==========================================================================
  logic deep_any;                              // Fast oscillators stopped
  assign deep_any = (state_q == ST_DEEP) || (state_q == ST_PPD);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_en        <= 1'b0;
      main_ext_clk_en    <= 1'b0;
      fast_osc_en        <= 1'b1;             // RQ2
      sub_osc_en         <= 1'b0;
      cpu_clk_gate       <= 1'b1;
      periph_power_en    <= 1'b1;
      slow_osc_to_periph <= 1'b1;
      fast_osc_freq      <= 3'h0;
      cpu_clk_sel        <= SRC_FAST;
    end else begin
      main_osc_en     <= !deep_any && !halt_q[BIT_MAIN_HALT]; // RQ1 RQ9
      main_ext_clk_en <= !deep_any && !halt_q[BIT_MAIN_HALT]; // RQ5
      fast_osc_en     <= !deep_any && !halt_q[BIT_FAST_HALT]; // RQ3 RQ9
      sub_osc_en      <= !halt_q[BIT_SUB_HALT];               // RQ6
      cpu_clk_gate    <= (state_q == ST_RUN);                 // RQ8
      periph_power_en <= (state_q != ST_PPD);                 // RQ11
      fast_osc_freq   <= freq_q;                              // RQ4
      cpu_clk_sel     <= src_q;                               // RQ2 RQ7
      // Slow osc never stops so wdt, rtc and timer keep waking
      slow_osc_to_periph <= 1'b1;                             // RQ7
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_OSC_CTRL:  reg_rdata <= {29'h0, halt_q};
        OFF_FREQ_SEL:  reg_rdata <= {29'h0, freq_q};
        OFF_CLK_SEL:   reg_rdata <= {29'h0, src_q};
        OFF_PMU_KEY:   reg_rdata <= {31'h0, arm_q};
        OFF_RST_CAUSE: reg_rdata <= {26'h0, cause_q};
        OFF_STATUS:    reg_rdata <= {24'h0, periph_power_en,
                                     fast_osc_en, main_osc_en, state_q};
        default:       reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence deep_entry_s;
    state_q == ST_RUN && deep_sleep_exec && !any_rst;
  endsequence
  deep_stops_fast_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    deep_entry_s |=> ##1 !fast_osc_en && !main_osc_en) // RQ9
    else $error("fast oscillators still running in deep sleep");
  sleep_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_SLEEP |=> !cpu_clk_gate) // RQ8
    else $error("processor clock open during sleep");
  sleep_wake_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_SLEEP && any_wake |=> ##1 cpu_clk_gate) // RQ20
    else $error("sleep wake did not reopen clock");
  ppd_power_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    deep_entry_s ##0 arm_q |=> ##1 !periph_power_en) // RQ11
    else $error("peripheral power not removed");
  ppd_wake_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_PPD && !ppd_wake && !any_rst |=> state_q == ST_PPD) // RQ12
    else $error("power-down left without allowed source");
  stab_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_DEEP && any_wake && src_q == SRC_MAIN && !any_rst
    |=> state_q == ST_STAB) // RQ10
    else $error("crystal wake skipped settling wait");
  reset_merge_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    any_rst |=> !internal_reset_n [*8]) // RQ15
    else $error("internal reset too short");
  sub_halt_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    halt_q[BIT_SUB_HALT] |=> !sub_osc_en) // RQ6
    else $error("sub oscillator running while halted");
endmodule : clock_power_reset_control

// ### test/clock_power_reset_control_tb_top.sv
// Purpose: Self-checking bench for the clock, power and reset control.
// Assumes: STAB_CYC cut to 4; option frequency code tied to 3.
// Notes:   Table rows cover register effects; hand tests follow.
`timescale 1ns/1ps

module clock_power_reset_control_tb_top
  import cpr_pkg::*;
;
  // ======================================================
  // Stimulus, observed outputs and counters
  // ======================================================
  logic        clk_sys = 1'b0;          // 250 MHz clock
  logic        reset_n = 1'b0;          // Held ten cycles
  logic        external_reset_pin_n = 1'b1;
  logic        por_low = 1'b0;
  logic        supply_level_low = 1'b0;
  logic        lvd_mode_irq = 1'b0;     // Reset mode first
  logic [2:0]  opt_freq_code = 3'h3;    // Option stand-in
  logic [3:0]  ev = 4'h0;               // Sleep,deep,runaway,illegal
  wake_t       wake_req = '0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, fetch_addr, d;
  logic [2:0]  fast_osc_freq, cpu_clk_sel;
  logic        main_osc_en, main_ext_clk_en, fast_osc_en, sub_osc_en;
  logic        cpu_clk_gate, slow_osc_to_periph, periph_power_en;
  logic        lvd_irq, internal_reset_n;
  int          mismatches = 0;
  int          compares = 0;

  // Short crystal wait keeps the wake tests brief
  clock_power_reset_control #(.STAB_CYC(4)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .external_reset_pin_n(external_reset_pin_n), .por_low(por_low),
    .supply_level_low(supply_level_low), .lvd_mode_irq(lvd_mode_irq),
    .opt_freq_code(opt_freq_code), .wake_req(wake_req),
    .sleep_exec(ev[0]), .deep_sleep_exec(ev[1]),
    .wdt_runaway(ev[2]), .illegal_access(ev[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_osc_en(main_osc_en),
    .main_ext_clk_en(main_ext_clk_en), .fast_osc_en(fast_osc_en),
    .fast_osc_freq(fast_osc_freq), .sub_osc_en(sub_osc_en),
    .cpu_clk_sel(cpu_clk_sel), .cpu_clk_gate(cpu_clk_gate),
    .slow_osc_to_periph(slow_osc_to_periph),
    .periph_power_en(periph_power_en), .lvd_irq(lvd_irq),
    .internal_reset_n(internal_reset_n), .fetch_addr(fetch_addr));

  always #2 clk_sys = ~clk_sys;

  // ======================================================
  // Bus, pulse and compare tasks
  // ======================================================
  // Wait n edges, then step past them so outputs are settled
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(logic [7:0] a, logic [31:0] w);
    @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, w, 1'b1};
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd

  // One-cycle event and wake pulses, then settle
  task automatic pl(logic [3:0] e, logic [5:0] w);
    @(posedge clk_sys) {ev, wake_req} <= {e, w};
    @(posedge clk_sys) {ev, wake_req} <= 10'h000;
    #1;
  endtask : pl

  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Bounded wait on the merged reset reaching level v
  task automatic wt(logic v);
    #1;
    for (int n = 0; n < 40 && internal_reset_n !== v; n++) cyc(1);
    chk(internal_reset_n, v);
  endtask : wt

  task automatic done(string s);
    $display("test %s done", s);
  endtask : done

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // ======================================================
  // Register table: offset, write, read back, osc enables
  // ======================================================
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [3:0]  o;                     // Main, ext, fast, sub
  } row_t;
  row_t rows [9] = '{
    '{OFF_OSC_CTRL, 32'h0, 32'h0, 4'hF},
    '{OFF_CLK_SEL, 32'h2, 32'h2, 4'hF},  // Run from sub osc
    '{OFF_CLK_SEL, 32'h3, 32'h3, 4'hF},  // Run from slow osc
    '{OFF_OSC_CTRL, 32'h1, 32'h1, 4'h3},
    '{OFF_OSC_CTRL, 32'h2, 32'h2, 4'hD},
    '{OFF_OSC_CTRL, 32'h4, 32'h4, 4'hE},
    '{OFF_FREQ_SEL, 32'h7, 32'h5, 4'hE}, // Above ceiling clamps
    '{OFF_FREQ_SEL, 32'h2, 32'h2, 4'hE},
    '{8'h1C, 32'hFF, 32'h0, 4'hE}};      // Unmapped place

  // ======================================================
  // Main sequence
  // ======================================================
  initial begin
    cyc(10);
    chk({fast_osc_en, cpu_clk_gate, periph_power_en,
         slow_osc_to_periph, internal_reset_n}, 5'h1E);
    @(posedge clk_sys) reset_n <= 1'b1;
    cyc(5);
    chk(internal_reset_n, 1'b0);
    cyc(6);
    chk({internal_reset_n, fast_osc_freq, cpu_clk_sel}, 7'h58);
    chk(fetch_addr, 32'h0);
    rd(OFF_OSC_CTRL, d);
    chk(d, OSC_CTRL_RST);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      cyc(2);
      rd(rows[i].a, d);
      chk(d, rows[i].r);
      chk({main_osc_en, main_ext_clk_en, fast_osc_en,
           sub_osc_en}, rows[i].o);
    end
    chk({cpu_clk_sel, fast_osc_freq}, 6'h1A);
    wr(OFF_OSC_CTRL, 32'h0);
    wr(OFF_CLK_SEL, 32'h0);
    done("table");
    // Sleep keeps oscillators, stops only the processor clock
    pl(4'h1, 6'h00);
    cyc(1);
    chk({cpu_clk_gate, main_osc_en, fast_osc_en, sub_osc_en}, 4'h7);
    rd(OFF_FREQ_SEL, d);
    chk(d, 32'h2);
    pl(4'h0, 6'h01);
    cyc(1);
    chk(cpu_clk_gate, 1'b1);
    done("sleep");
    // Deep sleep; the level detector still acts meanwhile
    pl(4'h2, 6'h00);
    cyc(1);
    chk({cpu_clk_gate, main_osc_en, fast_osc_en, sub_osc_en,
         periph_power_en}, 5'h03);
    rd(OFF_STATUS, d);
    chk(d, 32'h84);
    @(posedge clk_sys) {lvd_mode_irq, supply_level_low} <= 2'b11;
    cyc(3);
    chk({lvd_irq, internal_reset_n}, 2'b11);
    @(posedge clk_sys) {lvd_mode_irq, supply_level_low} <= 2'b00;
    pl(4'h0, 6'h01);
    cyc(1);
    chk({cpu_clk_gate, fast_osc_en}, 2'b11);
    // Crystal as clock: wake waits for settling
    wr(OFF_CLK_SEL, 32'h1);
    pl(4'h2, 6'h00);
    cyc(2);
    pl(4'h0, 6'h01);
    cyc(2);
    chk({cpu_clk_gate, main_osc_en}, 2'b01);
    cyc(8);
    chk(cpu_clk_gate, 1'b1);
    wr(OFF_CLK_SEL, 32'h0);
    done("deep");
    // Partial power-down: each listed source, others ignored
    for (int i = 1; i < 6; i++) begin
      wr(OFF_PMU_KEY, PMU_KEY_VALUE);
      pl(4'h2, 6'h00);
      cyc(1);
      rd(OFF_STATUS, d);
      chk(d, 32'h08);
      chk(periph_power_en, 1'b0);
      pl(4'h0, 6'h01);
      cyc(3);
      chk(periph_power_en, 1'b0);
      pl(4'h0, 6'(1 << i));
      cyc(3);
      chk({periph_power_en, cpu_clk_gate}, 2'b11);
      // Software sets its settings up again after each wake
      wr(OFF_FREQ_SEL, 32'h2);
    end
    done("power-down");
    // Every reset source, then its sticky cause bit
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: begin
          @(posedge clk_sys) external_reset_pin_n <= 1'b0;
          cyc(6);
          @(posedge clk_sys) external_reset_pin_n <= 1'b1;
        end
        1: pl(4'h4, 6'h00);
        2: begin
          @(posedge clk_sys) por_low <= 1'b1;
          cyc(3);
          @(posedge clk_sys) por_low <= 1'b0;
        end
        3: begin
          @(posedge clk_sys) supply_level_low <= 1'b1;
          cyc(3);
          @(posedge clk_sys) supply_level_low <= 1'b0;
        end
        4: pl(4'h8, 6'h00);
        default: wr(OFF_SW_RESET, SW_RESET_KEY);
      endcase
      wt(1'b0);
      wt(1'b1);
      rd(OFF_RST_CAUSE, d);
      chk(d, 32'(1 << k));
      chk(fetch_addr, 32'h0);
      wr(OFF_RST_CAUSE, 32'h3F);
    end
    done("resets");
    wrap_up();
  end

  // Whole run needs under 2000 cycles; 10000 means a hang
  initial begin
    #40000;
    mismatches++;
    wrap_up();
  end

endmodule : clock_power_reset_control_tb_top
